// file: rtl/mirq_device.sv
// Device end: interrupt request merging, APB registers and bus interrupt cycle
//
// Operation
// RL1 - Receive request: rx enable and character held
// RL2 - Receive request: storage enable and silo overflow
// RL3 - Transmit request: tx enable and lines done
// RL4 - Transmit request: tx enable and nonexistent memory
// RL5 - Two causes each merge into one request
// RL6 - Shared level; receive request wins ties
// RL7 - Request level chosen by configuration, default five
// RL8 - Pending request drives selected level request line
// RL9 - Host grants only highest level, acknowledge clear
// RL10 - Grant blocked from downstream while requesting
// RL11 - On grant: drop request, raise acknowledge
// RL12 - Host drops grant after acknowledge seen
// RL13 - Await busy and sync idle, take bus
// RL14 - As master: interrupt strobe plus vector
// RL15 - Host reads vector, then asserts slave sync
// RL16 - On slave sync release busy, strobe, vector
// RL17 - Host drops sync when strobe released
// RL18 - Own access timing out sets nonexistent memory
// RL19 - Nonexistent memory flag cleared by clear bit
// RL20 - Requests persist while their causes remain
// RL21 - One whole cycle before serving the other
`timescale 1ns/1ps
module mirq_device (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	mirq_bus_if.dev          bus,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        char_available,
	input  wire logic        silo_store_full,
	input  wire logic        tx_done,
	input  wire logic        dma_msyn,
	output logic             dma_abort,
	output logic             receive_irq_request,
	output logic             transmit_irq_request
);
	import mirq_pkg::*;

	// Register, watchdog and interrupt cycle state
	logic             rx_ie_q, rx_ie_d;
	logic             store_ie_q, store_ie_d;
	logic             tx_ie_q, tx_ie_d;
	logic             nxm_q, nxm_d;
	logic             ovf_q, ovf_d;
	logic [1:0]       cfg_lvl_q, cfg_lvl_d;
	logic [VEC_W-1:0] rx_vec_q, rx_vec_d;
	logic [VEC_W-1:0] tx_vec_q, tx_vec_d;
	logic             pready_q, pready_d;
	logic             pslverr_q, pslverr_d;
	logic [31:0]      prdata_q, prdata_d;
	logic             wr_en;
	logic [31:0]      rd_val;
	logic             mapped;
	logic [TO_W-1:0]  to_cnt_q, to_cnt_d;
	logic             abort_q, abort_d;
	logic             nxm_set;
	mirq_dev_state_e       state_q, state_d;
	logic                  serve_rx_q, serve_rx_d;
	logic [1:0]            lvl_q, lvl_d;
	logic [NUM_LEVELS-1:0] br_q, br_d;
	logic [NUM_LEVELS-1:0] bgo_q, bgo_d;
	logic                  sack_q, sack_d;
	logic                  master_q, master_d;
	logic [VEC_W-1:0]      vec_q, vec_d;
	logic                  rx_irq_q, rx_irq_d;
	logic                  tx_irq_q, tx_irq_d;
	logic                  rx_req, tx_req;

	assign rx_req = (rx_ie_q && char_available) || (store_ie_q && ovf_q); // RL1 RL2 RL5
	assign tx_req = tx_ie_q && (tx_done || nxm_q); // RL3 RL4 RL5
	assign wr_en  = psel && penable && pready_q && pwrite;
	always_comb
	begin
		mapped = 1'b1;
		rd_val = '0;
		unique case (paddr)
			SCR_OFF:
			begin
				rd_val[RX_IE_BIT]    = rx_ie_q;
				rd_val[CHAR_AV_BIT]  = char_available;
				rd_val[NXM_BIT]      = nxm_q;
				rd_val[STORE_IE_BIT] = store_ie_q;
				rd_val[TX_IE_BIT]    = tx_ie_q;
				rd_val[OVF_BIT]      = ovf_q;
			end
			CFG_OFF:
			begin
				rd_val[CFG_LVL_LSB +: 2]       = cfg_lvl_q;
				rd_val[CFG_RXVEC_LSB +: VEC_W] = rx_vec_q;
				rd_val[CFG_TXVEC_LSB +: VEC_W] = tx_vec_q;
			end
			STAT_OFF:
				rd_val = {24'h0, rx_req, tx_req, serve_rx_q, lvl_q, 1'b0, state_q};
			default:
				mapped = 1'b0;
		endcase
		rx_ie_d    = rx_ie_q;
		store_ie_d = store_ie_q;
		tx_ie_d    = tx_ie_q;
		cfg_lvl_d  = cfg_lvl_q;
		rx_vec_d   = rx_vec_q;
		tx_vec_d   = tx_vec_q;
		nxm_d      = nxm_q;
		ovf_d      = ovf_q;
		pready_d   = psel && !penable;
		pslverr_d  = psel && !penable && !mapped;
		prdata_d   = (psel && !penable) ? rd_val : prdata_q;
		if (wr_en && paddr == SCR_OFF)
		begin
			rx_ie_d    = pwdata[RX_IE_BIT];
			store_ie_d = pwdata[STORE_IE_BIT];
			tx_ie_d    = pwdata[TX_IE_BIT];
			if (pwdata[CLR_NXM_BIT])
				nxm_d = 1'b0; // RL19
			if (pwdata[OVF_BIT])
				ovf_d = 1'b0;
		end
		if (wr_en && paddr == CFG_OFF)
		begin
			cfg_lvl_d = pwdata[CFG_LVL_LSB +: 2]; // RL7
			rx_vec_d  = pwdata[CFG_RXVEC_LSB +: VEC_W];
			tx_vec_d  = pwdata[CFG_TXVEC_LSB +: VEC_W];
		end
		// Own bus access watchdog: abandon once per master sync
		to_cnt_d = '0;
		abort_d  = abort_q && dma_msyn;
		nxm_set  = 1'b0;
		if (dma_msyn && !bus.slave_sync_line && !abort_q)
		begin
			to_cnt_d = to_cnt_q + 1'b1;
			if (to_cnt_q == TO_W'(NXM_TIMEOUT_CYC - 1))
			begin
				to_cnt_d = '0;
				abort_d  = 1'b1;
				nxm_set  = 1'b1; // RL18
			end
		end
		// Hardware set wins over a clear in the same cycle
		if (nxm_set)
			nxm_d = 1'b1; // RL18
		if (silo_store_full)
			ovf_d = 1'b1; // RL2
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			rx_ie_q    <= 1'b0;
			store_ie_q <= 1'b0;
			tx_ie_q    <= 1'b0;
			cfg_lvl_q  <= CFG_LVL_RST;
			rx_vec_q   <= CFG_RXVEC_RST;
			tx_vec_q   <= CFG_TXVEC_RST;
			nxm_q      <= 1'b0;
			ovf_q      <= 1'b0;
			pready_q   <= 1'b0;
			pslverr_q  <= 1'b0;
			prdata_q   <= '0;
			to_cnt_q   <= '0;
			abort_q    <= 1'b0;
		end
		else
		begin
			rx_ie_q    <= rx_ie_d;
			store_ie_q <= store_ie_d;
			tx_ie_q    <= tx_ie_d;
			cfg_lvl_q  <= cfg_lvl_d;
			rx_vec_q   <= rx_vec_d;
			tx_vec_q   <= tx_vec_d;
			nxm_q      <= nxm_d;
			ovf_q      <= ovf_d;
			pready_q   <= pready_d;
			pslverr_q  <= pslverr_d;
			prdata_q   <= prdata_d;
			to_cnt_q   <= to_cnt_d;
			abort_q    <= abort_d;
		end
	end

	always_comb
	begin
		state_d    = state_q;
		serve_rx_d = serve_rx_q;
		lvl_d      = lvl_q;
		vec_d      = vec_q;
		unique case (state_q)
			ST_IDLE:
			begin
				// Re-evaluated only here, so a cycle always completes first
				if (rx_req || tx_req) // RL20 RL21
				begin
					serve_rx_d = rx_req; // RL6
					lvl_d      = cfg_lvl_q; // RL7
					state_d    = ST_REQ;
				end
			end
			ST_REQ:
				if ((bus.bus_grant_input & mirq_onehot(lvl_q)) != '0)
					state_d = ST_SACK; // RL11
			ST_SACK:
			begin
				if ((bus.bus_grant_input & mirq_onehot(lvl_q)) == '0
					&& !bus.bus_busy_line && !bus.slave_sync_line) // RL13
				begin
					vec_d   = serve_rx_q ? rx_vec_q : tx_vec_q; // RL14
					state_d = ST_MASTER;
				end
			end
			ST_MASTER:
				if (bus.slave_sync_line)
					state_d = ST_IDLE; // RL16
		endcase
		br_d     = (state_d == ST_REQ) ? mirq_onehot(lvl_d) : '0; // RL8
		sack_d   = (state_d == ST_SACK); // RL11
		master_d = (state_d == ST_MASTER); // RL13 RL14 RL16
		bgo_d    = bus.bus_grant_input & ~((state_d != ST_IDLE) ? mirq_onehot(lvl_d) : '0); // RL10
		rx_irq_d = rx_req;
		tx_irq_d = tx_req;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q    <= ST_IDLE;
			serve_rx_q <= 1'b0;
			lvl_q      <= CFG_LVL_RST;
			vec_q      <= '0;
			br_q       <= '0;
			sack_q     <= 1'b0;
			master_q   <= 1'b0;
			bgo_q      <= '0;
			rx_irq_q   <= 1'b0;
			tx_irq_q   <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			serve_rx_q <= serve_rx_d;
			lvl_q      <= lvl_d;
			vec_q      <= vec_d;
			br_q       <= br_d;
			sack_q     <= sack_d;
			master_q   <= master_d;
			bgo_q      <= bgo_d;
			rx_irq_q   <= rx_irq_d;
			tx_irq_q   <= tx_irq_d;
		end
	end

	assign bus.bus_request_level_line_oe  = br_q;
	assign bus.grant_passthrough_out      = bgo_q;
	assign bus.selection_acknowledge_oe   = sack_q;
	assign bus.dev_bus_busy_oe            = master_q;
	assign bus.interrupt_vector_strobe_oe = master_q;
	assign bus.vector_oe                  = master_q;
	assign bus.vector_out                 = vec_q;
	assign prdata                         = prdata_q;
	assign pready                         = pready_q;
	assign pslverr                        = pslverr_q;
	assign dma_abort                      = abort_q;
	assign receive_irq_request            = rx_irq_q;
	assign transmit_irq_request           = tx_irq_q;
endmodule

// file: rtl/mirq_pkg.sv
// Shared constants and types for the multiplexer interrupt requester
package mirq_pkg;

	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned NXM_TIMEOUT_US  = 20;
	localparam int unsigned NXM_TIMEOUT_CYC = (NXM_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned TO_W            = 12;

	localparam int unsigned NUM_LEVELS = 4;
	localparam int unsigned LEVEL_BASE = 4;
	localparam int unsigned VEC_W      = 7;

	localparam logic [7:0] SCR_OFF  = 8'h00;
	localparam logic [7:0] CFG_OFF  = 8'h04;
	localparam logic [7:0] STAT_OFF = 8'h08;

	localparam int unsigned RX_IE_BIT    = 6;
	localparam int unsigned CHAR_AV_BIT  = 7;
	localparam int unsigned CLR_NXM_BIT  = 8;
	localparam int unsigned NXM_BIT      = 10;
	localparam int unsigned STORE_IE_BIT = 12;
	localparam int unsigned TX_IE_BIT    = 13;
	localparam int unsigned OVF_BIT      = 14;

	localparam int unsigned CFG_LVL_LSB   = 0;
	localparam int unsigned CFG_RXVEC_LSB = 8;
	localparam int unsigned CFG_TXVEC_LSB = 16;
	localparam logic [1:0]       CFG_LVL_RST   = 2'h1;
	localparam logic [VEC_W-1:0] CFG_RXVEC_RST = 7'h00;
	localparam logic [VEC_W-1:0] CFG_TXVEC_RST = 7'h01;

	typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_SACK, ST_MASTER} mirq_dev_state_e;
	typedef enum logic [1:0] {H_IDLE, H_GRANT, H_WAIT_INTR, H_SSYN} mirq_host_state_e;

	function automatic logic [NUM_LEVELS-1:0] mirq_onehot(input logic [1:0] lvl);
		mirq_onehot = 4'h1 << lvl;
	endfunction

endpackage

// file: rtl/mirq_bus_if.sv
// Priority request bus joining the interrupt requester and the host arbiter
`timescale 1ns/1ps
interface mirq_bus_if;
	import mirq_pkg::*;

	logic [NUM_LEVELS-1:0] bus_request_level_line_oe;
	logic [NUM_LEVELS-1:0] bus_grant_input;
	logic [NUM_LEVELS-1:0] grant_passthrough_out;
	logic                  selection_acknowledge_oe;
	logic                  dev_bus_busy_oe;
	logic                  host_bus_busy_oe;
	logic                  interrupt_vector_strobe_oe;
	logic                  slave_sync_line_oe;
	logic                  vector_oe;
	logic [VEC_W-1:0]      vector_out;

	// Wired levels of the open-drain lines, asserted while any party drives
	logic [NUM_LEVELS-1:0] bus_request_level_line;
	logic                  selection_acknowledge;
	logic                  bus_busy_line;
	logic                  interrupt_vector_strobe;
	logic                  slave_sync_line;
	logic [VEC_W-1:0]      data_lines;

	assign bus_request_level_line  = bus_request_level_line_oe;
	assign selection_acknowledge   = selection_acknowledge_oe;
	assign bus_busy_line           = dev_bus_busy_oe | host_bus_busy_oe;
	assign interrupt_vector_strobe = interrupt_vector_strobe_oe;
	assign slave_sync_line         = slave_sync_line_oe;
	assign data_lines              = vector_oe ? vector_out : '0;

	modport dev (
		input  bus_grant_input, bus_busy_line, slave_sync_line,
		output bus_request_level_line_oe, grant_passthrough_out, selection_acknowledge_oe,
		output dev_bus_busy_oe, interrupt_vector_strobe_oe, vector_oe, vector_out
	);

	modport host (
		input  bus_request_level_line, selection_acknowledge, interrupt_vector_strobe,
		input  data_lines,
		output bus_grant_input, host_bus_busy_oe, slave_sync_line_oe
	);
endinterface

// file: rtl/mirq_host.sv
// Host processor end: bus arbiter that grants and takes the interrupt vector
`timescale 1ns/1ps
module mirq_host (
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	mirq_bus_if.host          bus,
	input  wire logic [2:0]   cpu_prio,
	input  wire logic         master_busy,
	output logic              irq_valid,
	output logic [mirq_pkg::VEC_W-1:0] irq_vector,
	output logic [2:0]        irq_level
);
	import mirq_pkg::*;

	mirq_host_state_e      state_q, state_d;
	logic [NUM_LEVELS-1:0] bg_q, bg_d;
	logic                  ssyn_q, ssyn_d;
	logic                  busy_q, busy_d;
	logic                  valid_q, valid_d;
	logic [VEC_W-1:0]      vec_q, vec_d;
	logic [2:0]            lvl_q, lvl_d;
	logic [2:0]            cand;
	logic                  found;

	always_comb
	begin
		state_d = state_q;
		bg_d    = bg_q;
		ssyn_d  = ssyn_q;
		busy_d  = master_busy;
		valid_d = 1'b0;
		vec_d   = vec_q;
		lvl_d   = lvl_q;
		found   = 1'b0;
		cand    = 3'h0;
		for (int i = 0; i < NUM_LEVELS; i++)
		begin
			if (bus.bus_request_level_line[i] && (3'(LEVEL_BASE + i) > cpu_prio))
			begin
				found = 1'b1;
				cand  = 3'(i);
			end
		end
		unique case (state_q)
			H_IDLE:
			begin
				if (found && !bus.selection_acknowledge) // RL9
				begin
					bg_d    = mirq_onehot(cand[1:0]);
					lvl_d   = 3'(LEVEL_BASE) + cand;
					state_d = H_GRANT;
				end
			end
			H_GRANT:
			begin
				if (bus.selection_acknowledge) // RL12
				begin
					bg_d    = '0;
					state_d = H_WAIT_INTR;
				end
				else if ((bus.bus_request_level_line & bg_q) == '0)
				begin
					bg_d    = '0;
					state_d = H_IDLE;
				end
			end
			H_WAIT_INTR:
			begin
				if (bus.interrupt_vector_strobe) // RL15
				begin
					vec_d   = bus.data_lines;
					ssyn_d  = 1'b1;
					state_d = H_SSYN;
				end
			end
			H_SSYN:
			begin
				if (!bus.interrupt_vector_strobe) // RL17
				begin
					ssyn_d  = 1'b0;
					valid_d = 1'b1;
					state_d = H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= H_IDLE;
			bg_q    <= '0;
			ssyn_q  <= 1'b0;
			busy_q  <= 1'b0;
			valid_q <= 1'b0;
			vec_q   <= '0;
			lvl_q   <= 3'h0;
		end
		else
		begin
			state_q <= state_d;
			bg_q    <= bg_d;
			ssyn_q  <= ssyn_d;
			busy_q  <= busy_d;
			valid_q <= valid_d;
			vec_q   <= vec_d;
			lvl_q   <= lvl_d;
		end
	end

	assign bus.bus_grant_input    = bg_q;
	assign bus.slave_sync_line_oe = ssyn_q;
	assign bus.host_bus_busy_oe   = busy_q;
	assign irq_valid              = valid_q;
	assign irq_vector             = vec_q;
	assign irq_level              = lvl_q;
endmodule

// file: test/mirq_assertions.sv
// Checker for the priority request link between requester and host
`timescale 1ns/1ps
module mirq_assertions (
	input wire logic                            clk_sys,
	input wire logic                            rstn,
	input wire logic [mirq_pkg::NUM_LEVELS-1:0] bus_request_level_line_oe,
	input wire logic [mirq_pkg::NUM_LEVELS-1:0] bus_grant_input,
	input wire logic [mirq_pkg::NUM_LEVELS-1:0] grant_passthrough_out,
	input wire logic                            selection_acknowledge_oe,
	input wire logic                            dev_bus_busy_oe,
	input wire logic                            interrupt_vector_strobe_oe,
	input wire logic                            slave_sync_line_oe,
	input wire logic                            vector_oe,
	input wire logic [mirq_pkg::VEC_W-1:0]      vector_out,
	input wire logic                            bus_busy_line
);
	import mirq_pkg::*;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	a_grant_acked: assert property ((bus_grant_input & bus_request_level_line_oe) != '0 |=>
		selection_acknowledge_oe && bus_request_level_line_oe == '0)
		else $error("no acknowledge after grant");
	a_grant_blocked: assert property ((bus_grant_input & bus_request_level_line_oe) != '0 |=>
		(grant_passthrough_out & $past(bus_grant_input)) == '0)
		else $error("grant passed downstream");
	a_take_bus: assert property ($rose(dev_bus_busy_oe) |-> !$past(bus_busy_line) &&
		!$past(slave_sync_line_oe) && $past(selection_acknowledge_oe) && !selection_acknowledge_oe)
		else $error("bus taken at wrong time");
	a_sack_bounded: assert property ($rose(selection_acknowledge_oe) |->
		##[1:100] $rose(dev_bus_busy_oe))
		else $error("mastership not taken");
	a_master_drive: assert property (dev_bus_busy_oe == interrupt_vector_strobe_oe &&
		vector_oe == dev_bus_busy_oe)
		else $error("strobe and vector not with busy");
	a_vector_held: assert property (interrupt_vector_strobe_oe && $past(interrupt_vector_strobe_oe)
		|-> $stable(vector_out))
		else $error("vector changed");
	a_sync_release: assert property (dev_bus_busy_oe && slave_sync_line_oe |=>
		!dev_bus_busy_oe && !interrupt_vector_strobe_oe && !vector_oe)
		else $error("bus not released");
	a_one_level: assert property ($onehot0(bus_request_level_line_oe))
		else $error("several request levels");
	a_no_overlap: assert property (selection_acknowledge_oe || dev_bus_busy_oe |->
		bus_request_level_line_oe == '0)
		else $error("request during cycle");
endmodule

// file: test/testbench.sv
// Self-checking bench for the interrupt requester and its host arbiter
`timescale 1ns/1ps
module testbench;
	import mirq_pkg::*;
	localparam logic [31:0] RXE = 32'h1 << RX_IE_BIT;
	localparam logic [31:0] TXE = 32'h1 << TX_IE_BIT;
	localparam logic [31:0] STE = 32'h1 << STORE_IE_BIT;
	localparam logic [31:0] OVF = 32'h1 << OVF_BIT;
	localparam logic [31:0] NXM = 32'h1 << NXM_BIT;
	logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr, irq_valid, master_busy;
	logic        char_available, silo_store_full, tx_done, dma_msyn, dma_abort;
	logic        receive_irq_request, transmit_irq_request;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [6:0]  irq_vector;
	logic [2:0]  irq_level, cpu_prio;
	int          fail_count, n_compared, n;

	mirq_bus_if bus ();
	mirq_device u_mirq_device (.clk_sys, .rstn, .bus(bus), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .char_available, .silo_store_full, .tx_done,
		.dma_msyn, .dma_abort, .receive_irq_request, .transmit_irq_request);
	mirq_host u_mirq_host (.clk_sys, .rstn, .bus(bus), .cpu_prio, .master_busy, .irq_valid,
		.irq_vector, .irq_level);
	mirq_assertions u_mirq_assertions (.clk_sys(clk_sys), .rstn(rstn),
		.bus_request_level_line_oe(bus.bus_request_level_line_oe),
		.bus_grant_input(bus.bus_grant_input), .grant_passthrough_out(bus.grant_passthrough_out),
		.selection_acknowledge_oe(bus.selection_acknowledge_oe),
		.dev_bus_busy_oe(bus.dev_bus_busy_oe),
		.interrupt_vector_strobe_oe(bus.interrupt_vector_strobe_oe),
		.slave_sync_line_oe(bus.slave_sync_line_oe), .vector_oe(bus.vector_oe),
		.vector_out(bus.vector_out), .bus_busy_line(bus.bus_busy_line));

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			fail_count++;
			complete_run();
		end
		else
			@(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
		input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		check(r & m, x);
		check({31'h0, e}, {31'h0, xe});
	endtask

	// Waits for the host to take a vector; a nonzero mask also checks the request lines
	task automatic wirq(input logic [6:0] v, input logic [1:0] l, input logic [3:0] m);
		logic [3:0] seen;
		seen = '0;
		n = 0;
		do
		begin
			@(negedge clk_sys);
			seen = seen | bus.bus_request_level_line;
			n++;
		end
		while (irq_valid !== 1'b1 && n < 3000);
		if (irq_valid !== 1'b1)
		begin
			fail_count++;
			complete_run();
		end
		else
		begin
			check({25'h0, irq_vector}, {25'h0, v});
			check({29'h0, irq_level}, {29'h0, 1'b1, l});
			if (m != '0)
				check({28'h0, seen}, {28'h0, m});
			@(posedge clk_sys);
		end
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial
	begin
		{rstn, psel, penable, pwrite, char_available, silo_store_full, tx_done} = '0;
		{dma_msyn, master_busy, paddr, pwdata, cpu_prio, fail_count, n_compared} = '0;
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		rd(CFG_OFF, '1, 32'h00010001, 1'b0);
		rd(SCR_OFF, '1, 32'h0, 1'b0);
		rd(8'h0C, '1, 32'h0, 1'b1);
		// Transmit done while the host is busy and masked, then unmasked before busy ends
		master_busy <= 1'b1;
		cpu_prio <= 3'h5;
		wr(SCR_OFF, TXE);
		tx_done <= 1'b1;
		repeat (20) @(posedge clk_sys);
		check({31'h0, transmit_irq_request}, 32'h1);
		check({28'h0, bus.bus_request_level_line}, 32'h2);
		check({31'h0, bus.selection_acknowledge}, 32'h0);
		cpu_prio <= 3'h0;
		repeat (10) @(posedge clk_sys);
		check({31'h0, bus.selection_acknowledge}, 32'h1);
		master_busy <= 1'b0;
		wirq(CFG_TXVEC_RST, 2'h1, 4'h0);
		wirq(CFG_TXVEC_RST, 2'h1, 4'h2);
		tx_done <= 1'b0;
		wr(SCR_OFF, 32'h0);
		repeat (30) @(posedge clk_sys);
		for (int i = 0; i < 4; i++)
		begin
			wr(CFG_OFF, {9'h0, 5'h08, i[1:0], 1'b0, 5'h04, i[1:0], 6'h0, i[1:0]});
			wr(SCR_OFF, TXE);
			tx_done <= 1'b1;
			wirq({5'h08, i[1:0]}, i[1:0], 4'h1 << i[1:0]);
			tx_done <= 1'b0;
			wr(SCR_OFF, 32'h0);
			repeat (30) @(posedge clk_sys);
		end
		// Both causes at once: receive first, then one whole cycle for transmit
		wr(CFG_OFF, 32'h00443301);
		wr(SCR_OFF, RXE | TXE);
		char_available <= 1'b1;
		tx_done <= 1'b1;
		n = 0;
		do
			@(negedge clk_sys);
		while (bus.selection_acknowledge !== 1'b1 && ++n < 200);
		if (bus.selection_acknowledge !== 1'b1)
		begin
			fail_count++;
			complete_run();
		end
		else
			check({31'h0, receive_irq_request}, 32'h1);
		@(posedge clk_sys);
		char_available <= 1'b0;
		wirq(7'h33, 2'h1, 4'h0);
		wirq(7'h44, 2'h1, 4'h2);
		tx_done <= 1'b0;
		// Let the cycle already under way for the held cause finish first
		repeat (30) @(posedge clk_sys);
		wr(SCR_OFF, STE);
		silo_store_full <= 1'b1;
		@(posedge clk_sys);
		silo_store_full <= 1'b0;
		wirq(7'h33, 2'h1, 4'h0);
		rd(SCR_OFF, OVF, OVF, 1'b0);
		wr(SCR_OFF, STE | OVF);
		repeat (30) @(posedge clk_sys);
		check({31'h0, receive_irq_request}, 32'h0);
		// Own access without answer runs into the timeout
		wr(SCR_OFF, TXE);
		dma_msyn <= 1'b1;
		n = 0;
		do
			@(negedge clk_sys);
		while (dma_abort !== 1'b1 && ++n < 2100);
		if (dma_abort !== 1'b1)
		begin
			fail_count++;
			complete_run();
		end
		else
			check({31'h0, n >= 1995 && n <= 2005}, 32'h1);
		wirq(7'h44, 2'h1, 4'h2);
		dma_msyn <= 1'b0;
		rd(SCR_OFF, NXM, NXM, 1'b0);
		wr(SCR_OFF, 32'h1 << CLR_NXM_BIT);
		repeat (30) @(posedge clk_sys);
		rd(SCR_OFF, NXM, 32'h0, 1'b0);
		check({31'h0, dma_abort}, 32'h0);
		complete_run();
	end
endmodule
